// ---- crp_pkg.sv ----
// Register map, field positions and reset values for the channel register paging block
package crp_pkg;
   localparam int CRP_NCH = 4;
   localparam logic [7:0] CRP_A_RST = 8'h00;
   localparam logic [7:0] CRP_A_LOSS = 8'h01;
   localparam logic [7:0] CRP_A_BOOST = 8'h03;
   localparam logic [7:0] CRP_A_CAP0 = 8'h08;
   localparam logic [7:0] CRP_A_OVEN = 8'h09;
   localparam logic [7:0] CRP_A_RCOV = 8'h0a;
   localparam logic [7:0] CRP_A_CAP1 = 8'h0b;
   localparam logic [7:0] CRP_A_PATCLK = 8'h0d;
   localparam logic [7:0] CRP_A_EYE = 8'h11;
   localparam logic [7:0] CRP_A_LIMIT = 8'h13;
   localparam logic [7:0] CRP_A_SDF = 8'h14;
   localparam logic [7:0] CRP_A_DEEMP = 8'h15;
   localparam logic [7:0] CRP_A_DIV = 8'h18;
   localparam logic [7:0] CRP_A_SEL = 8'hff;
   // Select register fields
   localparam int CRP_SEL_BCAST = 3;
   localparam int CRP_SEL_CHEN = 2;
   // Channel register fields
   localparam int CRP_RST_BIT = 2;
   localparam int CRP_LOCK_LOSS_BIT = 4;
   localparam int CRP_SD_LOSS_BIT = 0;
   localparam int CRP_CAP_OV_BIT = 7;
   localparam int CRP_MUX_OV_BIT = 5;
   localparam int CRP_DIV_OV_BIT = 2;
   localparam int CRP_RC_OV_EN_BIT = 3;
   localparam int CRP_RC_OV_VAL_BIT = 2;
   localparam int CRP_EYE_PD_BIT = 5;
   localparam int CRP_LIMIT_BIT = 2;
   // Writable masks and reset values
   localparam logic [7:0] CRP_M_CAP = 8'h1f;
   localparam logic [7:0] CRP_M_OVEN = 8'ha4;
   localparam logic [7:0] CRP_M_RCOV = 8'h0c;
   localparam logic [7:0] CRP_M_PATCLK = 8'h20;
   localparam logic [7:0] CRP_M_EYE = 8'he0;
   localparam logic [7:0] CRP_M_LIMIT = 8'h04;
   localparam logic [7:0] CRP_M_SDF = 8'hc0;
   localparam logic [7:0] CRP_M_DEEMP = 8'h47;
   localparam logic [7:0] CRP_M_DIV = 8'h74;
   localparam logic [7:0] CRP_RV_CAP1 = 8'h0f;
   localparam logic [7:0] CRP_RV_EYE = 8'h20;
   localparam logic [7:0] CRP_RV_DIV = 8'h40;
   localparam logic [7:0] CRP_RV_SEL = 8'h00;
   localparam logic [7:0] CRP_INVALID_RD = 8'h00;
endpackage : crp_pkg

// ---- crp_chan_regs.sv ----
// One channel register set with its overrides and loss flags
`timescale 1ns/10ps
`default_nettype none
module crp_chan_regs
   import crp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register access
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // Analog status; loss flags already synchronised, seq_recovery_reset not synchronised
   input wire logic lock_loss,
   input wire logic sd_loss,
   input wire logic seq_recovery_reset,
   // Effective controls
   output logic recovery_reset,
   output logic cap_ov_en,
   output logic [4:0] cap_setting_zero,
   output logic [4:0] cap_setting_one,
   output logic output_mux_override_enable,
   output logic divider_override_enable,
   output logic [2:0] divider_ratio,
   output logic [2:0] last_stage_boost,
   output logic eye_monitor_powerdown
);
   logic [7:0] boost_q, cap0_q, oven_q, rcov_q, cap1_q, patclk_q, eye_q, limit_q, sdf_q, deemp_q, div_q;
   logic chrst;

   assign chrst = wr_en && addr == CRP_A_RST && wdata[CRP_RST_BIT];

   always_ff @(posedge clk)
   begin
      if (srst || chrst)
      begin
         boost_q <= 8'h00;
         cap0_q <= 8'h00;
         oven_q <= 8'h00;
         rcov_q <= 8'h00;
         cap1_q <= CRP_RV_CAP1;
         patclk_q <= 8'h00;
         eye_q <= CRP_RV_EYE;
         limit_q <= 8'h00;
         sdf_q <= 8'h00;
         deemp_q <= 8'h00;
         div_q <= CRP_RV_DIV;
      end
      else if (wr_en)
      begin
         unique case (addr)
            CRP_A_BOOST: boost_q <= wdata;
            CRP_A_CAP0: cap0_q <= wdata & CRP_M_CAP;
            CRP_A_OVEN: oven_q <= wdata & CRP_M_OVEN;
            CRP_A_RCOV: rcov_q <= wdata & CRP_M_RCOV;
            CRP_A_CAP1: cap1_q <= wdata & CRP_M_CAP;
            CRP_A_PATCLK: patclk_q <= wdata & CRP_M_PATCLK;
            CRP_A_EYE: eye_q <= wdata & CRP_M_EYE;
            CRP_A_LIMIT: limit_q <= wdata & CRP_M_LIMIT;
            CRP_A_SDF: sdf_q <= wdata & CRP_M_SDF;
            CRP_A_DEEMP: deemp_q <= wdata & CRP_M_DEEMP;
            CRP_A_DIV: div_q <= wdata & CRP_M_DIV;
            default: ;
         endcase
      end
   end

   always_comb
   begin
      unique case (addr)
         CRP_A_RST: rdata = 8'h00;
         CRP_A_LOSS:
         begin
            rdata = 8'h00;
            rdata[CRP_LOCK_LOSS_BIT] = lock_loss;
            rdata[CRP_SD_LOSS_BIT] = sd_loss;
         end
         CRP_A_BOOST: rdata = boost_q;
         CRP_A_CAP0: rdata = cap0_q;
         CRP_A_OVEN: rdata = oven_q;
         CRP_A_RCOV: rdata = rcov_q;
         CRP_A_CAP1: rdata = cap1_q;
         CRP_A_PATCLK: rdata = patclk_q;
         CRP_A_EYE: rdata = eye_q;
         CRP_A_LIMIT: rdata = limit_q;
         CRP_A_SDF: rdata = sdf_q;
         CRP_A_DEEMP: rdata = deemp_q;
         CRP_A_DIV: rdata = div_q;
         default: rdata = 8'h00;
      endcase
   end

   assign recovery_reset = rcov_q[CRP_RC_OV_EN_BIT] ? rcov_q[CRP_RC_OV_VAL_BIT] : seq_recovery_reset;
   assign cap_ov_en = oven_q[CRP_CAP_OV_BIT];
   assign cap_setting_zero = cap0_q[4:0];
   assign cap_setting_one = cap1_q[4:0];
   assign output_mux_override_enable = oven_q[CRP_MUX_OV_BIT];
   assign divider_override_enable = oven_q[CRP_DIV_OV_BIT];
   assign divider_ratio = div_q[6:4];
   assign last_stage_boost = {limit_q[CRP_LIMIT_BIT], boost_q[1:0]};
   assign eye_monitor_powerdown = eye_q[CRP_EYE_PD_BIT];
endmodule : crp_chan_regs
`default_nettype wire

// ---- crp_top.sv ----
// Register-set steering between shared and four channel register sets
`timescale 1ns/10ps
`default_nettype none
module crp_top
   import crp_pkg::*;
#(
   parameter int NCH = CRP_NCH
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port from the bus engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Shared register set, outside this block
   output logic shared_wr,
   output logic shared_rd,
   output logic [7:0] shared_addr,
   output logic [7:0] shared_wdata,
   input wire logic [7:0] shared_rdata,
   // Analog status per channel, asynchronous
   input wire logic [NCH-1:0] lock_loss_in,
   input wire logic [NCH-1:0] sd_loss_in,
   input wire logic [NCH-1:0] seq_recovery_reset,
   // Per-channel controls
   output logic [NCH-1:0] recovery_reset,
   output logic [NCH-1:0] cap_setting_override_enable,
   output logic [NCH*5-1:0] cap_setting_zero,
   output logic [NCH*5-1:0] cap_setting_one,
   output logic [NCH-1:0] output_mux_override_enable,
   output logic [NCH-1:0] divider_override_enable,
   output logic [NCH*3-1:0] divider_ratio,
   output logic [NCH*3-1:0] last_stage_boost,
   output logic [NCH-1:0] eye_monitor_powerdown
);
   logic [7:0] sel_q;
   logic [NCH-1:0] lock_s1_q, lock_s2_q, sd_s1_q, sd_s2_q;
   logic chan_space, bcast, sel_wr;
   logic [1:0] target;
   logic [NCH-1:0] ch_wr;
   logic [7:0] ch_rdata [NCH];
   logic [NCH-1:0] rr_w, cap_ov_w, mux_ov_w, div_ov_w, pd_w;
   logic [NCH*5-1:0] cap0_w, cap1_w;
   logic [NCH*3-1:0] ratio_w, boost_w;

   assign chan_space = sel_q[CRP_SEL_CHEN];
   assign bcast = sel_q[CRP_SEL_BCAST];
   assign target = sel_q[1:0];
   assign sel_wr = reg_wr && reg_addr == CRP_A_SEL;

   always_ff @(posedge clk)
   begin
      if (srst)
         sel_q <= CRP_RV_SEL;
      else if (sel_wr)
         sel_q <= reg_wdata;
   end

   // Two-stage sync, flags come from the analog side
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lock_s1_q <= '0;
         lock_s2_q <= '0;
         sd_s1_q <= '0;
         sd_s2_q <= '0;
      end
      else
      begin
         lock_s1_q <= lock_loss_in;
         lock_s2_q <= lock_s1_q;
         sd_s1_q <= sd_loss_in;
         sd_s2_q <= sd_s1_q;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NCH; i++)
         ch_wr[i] = reg_wr && !sel_wr && chan_space && (bcast || target == 2'(i));
   end

   for (genvar g = 0; g < NCH; g++)
   begin : g_ch
      crp_chan_regs u_regs (
         .clk(clk),
         .srst(srst),
         .wr_en(ch_wr[g]),
         .addr(reg_addr),
         .wdata(reg_wdata),
         .rdata(ch_rdata[g]),
         .lock_loss(lock_s2_q[g]),
         .sd_loss(sd_s2_q[g]),
         .seq_recovery_reset(seq_recovery_reset[g]),
         .recovery_reset(rr_w[g]),
         .cap_ov_en(cap_ov_w[g]),
         .cap_setting_zero(cap0_w[g*5 +: 5]),
         .cap_setting_one(cap1_w[g*5 +: 5]),
         .output_mux_override_enable(mux_ov_w[g]),
         .divider_override_enable(div_ov_w[g]),
         .divider_ratio(ratio_w[g*3 +: 3]),
         .last_stage_boost(boost_w[g*3 +: 3]),
         .eye_monitor_powerdown(pd_w[g])
      );
   end

   // Registered controls, one cycle behind the sets
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         recovery_reset <= '0;
         cap_setting_override_enable <= '0;
         cap_setting_zero <= '0;
         cap_setting_one <= {NCH{CRP_RV_CAP1[4:0]}};
         output_mux_override_enable <= '0;
         divider_override_enable <= '0;
         divider_ratio <= {NCH{CRP_RV_DIV[6:4]}};
         last_stage_boost <= '0;
         eye_monitor_powerdown <= '1;
      end
      else
      begin
         recovery_reset <= rr_w;
         cap_setting_override_enable <= cap_ov_w;
         cap_setting_zero <= cap0_w;
         cap_setting_one <= cap1_w;
         output_mux_override_enable <= mux_ov_w;
         divider_override_enable <= div_ov_w;
         divider_ratio <= ratio_w;
         last_stage_boost <= boost_w;
         eye_monitor_powerdown <= pd_w;
      end
   end

   // shared set reached only with channel space off
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         shared_wr <= 1'b0;
         shared_rd <= 1'b0;
         shared_addr <= 8'h00;
         shared_wdata <= 8'h00;
      end
      else
      begin
         shared_wr <= reg_wr && !sel_wr && !chan_space;
         shared_rd <= reg_rd && reg_addr != CRP_A_SEL && !chan_space;
         shared_addr <= reg_addr;
         shared_wdata <= reg_wdata;
      end
   end

   // Read path: channel data held one cycle to line up with the shared cycle, both answered two edges after the read
   logic rd_sh_q, rd_ch_q;
   logic [7:0] ch_hold_q;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_sh_q <= 1'b0;
         rd_ch_q <= 1'b0;
         ch_hold_q <= 8'h00;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         rd_sh_q <= reg_rd && reg_addr != CRP_A_SEL && !chan_space;
         rd_ch_q <= reg_rd && (reg_addr == CRP_A_SEL || chan_space);
         ch_hold_q <= reg_addr == CRP_A_SEL ? CRP_INVALID_RD : ch_rdata[target];
         reg_rvalid <= rd_sh_q || rd_ch_q;
         if (rd_sh_q)
            reg_rdata <= shared_rdata;
         else if (rd_ch_q)
            reg_rdata <= ch_hold_q;
      end
   end

   // Assertions: select register and write steering
   a_sel_hold: assert property (@(posedge clk) disable iff (srst)
      !sel_wr |=> $stable(sel_q))
      else $error("select changed without write");

   a_sel_load: assert property (@(posedge clk) disable iff (srst)
      sel_wr |=> sel_q == $past(reg_wdata))
      else $error("select not loaded");

   a_sel_rst: assert property (@(posedge clk)
      srst |=> sel_q == CRP_RV_SEL)
      else $error("select not cleared by reset");

   a_bcast_all: assert property (@(posedge clk) disable iff (srst)
      reg_wr && !sel_wr && chan_space && bcast |-> ch_wr == '1)
      else $error("broadcast missed a channel");

   a_single_tgt: assert property (@(posedge clk) disable iff (srst)
      reg_wr && !sel_wr && chan_space && !bcast |-> $onehot(ch_wr))
      else $error("targeted write not single");

   a_tgt_hit: assert property (@(posedge clk) disable iff (srst)
      reg_wr && !sel_wr && chan_space |-> ch_wr[target])
      else $error("selected channel not written");

   a_sel_no_chan: assert property (@(posedge clk) disable iff (srst)
      sel_wr |-> ch_wr == '0)
      else $error("select write reached a channel");

   a_sel_no_shared: assert property (@(posedge clk) disable iff (srst)
      sel_wr |=> !shared_wr)
      else $error("select write reached the shared set");

   // Assertions: shared set gating
   a_shared_gate: assert property (@(posedge clk) disable iff (srst)
      reg_wr && chan_space |=> !shared_wr)
      else $error("shared write in channel space");

   a_chan_gate: assert property (@(posedge clk) disable iff (srst)
      !chan_space |-> ch_wr == '0)
      else $error("channel write outside channel space");

   a_shared_wr_map: assert property (@(posedge clk) disable iff (srst)
      reg_wr && !sel_wr && !chan_space
      |=> shared_wr && shared_addr == $past(reg_addr) && shared_wdata == $past(reg_wdata))
      else $error("shared write lost or altered");

   a_shared_rd_map: assert property (@(posedge clk) disable iff (srst)
      reg_rd && reg_addr != CRP_A_SEL && !chan_space
      |=> shared_rd && shared_addr == $past(reg_addr))
      else $error("shared read lost or altered");

   a_chan_no_shrd: assert property (@(posedge clk) disable iff (srst)
      reg_rd && chan_space |=> !shared_rd)
      else $error("shared read in channel space");

   a_shared_quiet: assert property (@(posedge clk) disable iff (srst)
      !reg_wr && !reg_rd |=> !shared_wr && !shared_rd)
      else $error("shared access without request");

   // Assertions: read answers, two edges after the strobe
   a_rd_pulse: assert property (@(posedge clk) disable iff (srst)
      reg_rd |-> ##2 reg_rvalid)
      else $error("read not answered");

   a_rvalid_gap: assert property (@(posedge clk) disable iff (srst)
      !reg_rd |-> ##2 !reg_rvalid)
      else $error("answer without read");

   a_rdata_hold: assert property (@(posedge clk) disable iff (srst)
      !reg_rd |-> ##2 $stable(reg_rdata))
      else $error("read data moved without read");

   a_rd_target: assert property (@(posedge clk) disable iff (srst)
      reg_rd && chan_space && reg_addr != CRP_A_SEL
      |-> ##2 reg_rvalid && reg_rdata == $past(ch_rdata[target], 2))
      else $error("channel read from wrong set");

   a_shared_data: assert property (@(posedge clk) disable iff (srst)
      reg_rd && !chan_space && reg_addr != CRP_A_SEL
      |-> ##2 reg_rvalid && reg_rdata == $past(shared_rdata))
      else $error("shared read data lost");

   a_sel_invalid: assert property (@(posedge clk) disable iff (srst)
      reg_rd && reg_addr == CRP_A_SEL |-> ##2 reg_rdata == CRP_INVALID_RD)
      else $error("select readback leaked");

   a_sel_rd_local: assert property (@(posedge clk) disable iff (srst)
      reg_rd && reg_addr == CRP_A_SEL |=> !shared_rd)
      else $error("select read reached the shared set");

   // Assertions: reset state of the registered controls
   a_eye_pd_rst: assert property (@(posedge clk)
      srst |=> eye_monitor_powerdown == '1)
      else $error("monitor not off after reset");

   a_rst_defaults: assert property (@(posedge clk)
      srst |=> cap_setting_one == {NCH{CRP_RV_CAP1[4:0]}} && divider_ratio == {NCH{CRP_RV_DIV[6:4]}}
      && recovery_reset == '0 && last_stage_boost == '0)
      else $error("controls not at defaults after reset");

   // Per channel; a control shows a register change two edges after the write
   for (genvar g = 0; g < NCH; g++)
   begin : g_chk
      a_ch_rst_default: assert property (@(posedge clk) disable iff (srst)
         ch_wr[g] && reg_addr == CRP_A_RST && reg_wdata[CRP_RST_BIT]
         |=> ##1 eye_monitor_powerdown[g] && cap_setting_one[g*5 +: 5] == CRP_RV_CAP1[4:0]
         && divider_ratio[g*3 +: 3] == CRP_RV_DIV[6:4] && last_stage_boost[g*3 +: 3] == 3'h0)
         else $error("channel reset left a setting");

      a_ch_loss_rd: assert property (@(posedge clk) disable iff (srst)
         reg_rd && chan_space && target == 2'(g) && reg_addr == CRP_A_LOSS
         |-> ##2 reg_rdata[CRP_LOCK_LOSS_BIT] == $past(lock_s2_q[g], 2)
         && reg_rdata[CRP_SD_LOSS_BIT] == $past(sd_s2_q[g], 2))
         else $error("loss flags from wrong channel");

      a_ch_rst_clear: assert property (@(posedge clk) disable iff (srst)
         reg_rd && chan_space && target == 2'(g) && reg_addr == CRP_A_RST
         |-> ##2 reg_rdata == 8'h00)
         else $error("channel reset bit not self cleared");

      a_ch_untouched: assert property (@(posedge clk) disable iff (srst)
         !ch_wr[g] |=> ##1 $stable(cap_setting_one[g*5 +: 5]) && $stable(divider_ratio[g*3 +: 3])
         && $stable(eye_monitor_powerdown[g]) && $stable(last_stage_boost[g*3 +: 3]))
         else $error("unwritten channel changed");

      a_tgt_only: assert property (@(posedge clk) disable iff (srst)
         reg_wr && chan_space && !bcast && target != 2'(g) |-> !ch_wr[g])
         else $error("targeted write reached another channel");
   end
endmodule : crp_top
`default_nettype wire

// ---- crp_shared_model.sv ----
// Behavioural shared register set answering the paging block
`timescale 1ns/10ps
`default_nettype none
module crp_shared_model
   import crp_pkg::*;
(
   // Clock
   input wire logic clk,
   // Shared register access
   input wire logic shared_wr,
   input wire logic shared_rd,
   input wire logic [7:0] shared_addr,
   input wire logic [7:0] shared_wdata,
   output var logic [7:0] shared_rdata
);
   logic [7:0] mem [256];
   logic [7:0] last_q;
   // Contents a5 xor address, zero only at address a5, so a stray shared access is visible
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'ha5 ^ 8'(i);
   end
   // Plain always, the array is also preloaded above
   always @(posedge clk)
   begin
      if (shared_wr)
         mem[shared_addr] <= shared_wdata;
      if (shared_rd)
         last_q <= mem[shared_addr];
   end
   // Released bus shows the inverse, never a stale match
   always_comb
   begin
      shared_rdata = shared_rd ? mem[shared_addr] : ~last_q;
   end
endmodule : crp_shared_model
`default_nettype wire

// ---- test_channel_register_paging.sv ----
// Self-checking testbench for the channel register paging block
`timescale 1ns/10ps
`default_nettype none
module test_channel_register_paging
   import crp_pkg::*;
;
   logic clk, srst, reg_wr, reg_rd, reg_rvalid, sh_wr, sh_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sh_addr, sh_wdata, sh_rdata;
   logic [3:0] lock_loss, sd_loss, seq_rr, rr, cap_ov, mux_ov, div_ov, eye_pd;
   logic [19:0] cap0, cap1;
   logic [11:0] div_ratio, boost;
   int fails = 0;
   int n_checks = 0;
   crp_top #(.NCH(4)) u_dut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .shared_wr(sh_wr), .shared_rd(sh_rd), .shared_addr(sh_addr), .shared_wdata(sh_wdata),
      .shared_rdata(sh_rdata), .lock_loss_in(lock_loss), .sd_loss_in(sd_loss),
      .seq_recovery_reset(seq_rr), .recovery_reset(rr), .cap_setting_override_enable(cap_ov),
      .cap_setting_zero(cap0), .cap_setting_one(cap1), .output_mux_override_enable(mux_ov),
      .divider_override_enable(div_ov), .divider_ratio(div_ratio), .last_stage_boost(boost),
      .eye_monitor_powerdown(eye_pd));
   crp_shared_model u_shared (.clk(clk), .shared_wr(sh_wr), .shared_rd(sh_rd), .shared_addr(sh_addr),
      .shared_wdata(sh_wdata), .shared_rdata(sh_rdata));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read, wait a bounded time for the answer, compare
   task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      d = 8'hxx;
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         if (reg_rvalid === 1'b1)
         begin
            d = reg_rdata;
            break;
         end
      end
      chk(what, d, exp);
   endtask : rc
   // Controls lag the registers by a cycle
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask : settle
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   initial
   begin
      #100000;
      fails++;
      end_sim();
   end
   initial
   begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      lock_loss = 4'h0;
      sd_loss = 4'h0;
      seq_rr = 4'h0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk("eye powerdown", {4'h0, eye_pd}, 8'h0f);
      chk("cap one", {3'h0, cap1[4:0]}, CRP_RV_CAP1);
      wr(8'h10, 8'h5a);
      rc(8'h10, 8'h5a, "shared data");
      rc(CRP_A_SEL, CRP_INVALID_RD, "select read");
      for (int ch = 0; ch < 4; ch++)
      begin
         wr(CRP_A_SEL, 8'h04 | 8'(ch));
         wr(CRP_A_DEEMP, 8'h40 | 8'(ch));
         rc(CRP_A_EYE, CRP_RV_EYE, "eye default");
         rc(CRP_A_DIV, CRP_RV_DIV, "divider default");
      end
      for (int ch = 0; ch < 4; ch++)
      begin
         wr(CRP_A_SEL, 8'h04 | 8'(ch));
         rc(CRP_A_DEEMP, 8'h40 | 8'(ch), "targeted deemph");
         rc(CRP_A_RST, 8'h00, "channel addr zero");
      end
      wr(CRP_A_SEL, 8'h0e);
      wr(CRP_A_BOOST, 8'h9b);
      for (int ch = 0; ch < 4; ch++)
      begin
         wr(CRP_A_SEL, 8'h0c | 8'(ch));
         rc(CRP_A_BOOST, 8'h9b, "broadcast boost");
         rc(CRP_A_DEEMP, 8'h40 | 8'(ch), "broadcast read");
      end
      wr(CRP_A_SEL, 8'h05);
      wr(CRP_A_RST, 8'h04);
      rc(CRP_A_DEEMP, 8'h00, "reset deemph");
      rc(CRP_A_RST, 8'h00, "reset self clear");
      wr(CRP_A_SEL, 8'h06);
      rc(CRP_A_DEEMP, 8'h42, "untouched deemph");
      wr(CRP_A_SEL, 8'h0c);
      wr(CRP_A_RST, 8'h04);
      for (int ch = 0; ch < 4; ch++)
      begin
         wr(CRP_A_SEL, 8'h04 | 8'(ch));
         rc(CRP_A_DEEMP, 8'h00, "broadcast reset");
         rc(CRP_A_CAP1, CRP_RV_CAP1, "cap one default");
      end
      @(posedge clk);
      lock_loss <= 4'h4;
      sd_loss <= 4'h4;
      wr(CRP_A_SEL, 8'h06);
      wr(CRP_A_LOSS, 8'hff);
      settle();
      rc(CRP_A_LOSS, 8'h11, "loss flags");
      wr(CRP_A_SEL, 8'h07);
      rc(CRP_A_LOSS, 8'h00, "quiet flags");
      @(posedge clk);
      seq_rr <= 4'h8;
      settle();
      chk("sequenced reset", {4'h0, rr}, 8'h08);
      wr(CRP_A_RCOV, 8'h08);
      settle();
      chk("override low", {4'h0, rr}, 8'h00);
      wr(CRP_A_RCOV, 8'h0c);
      @(posedge clk);
      seq_rr <= 4'h0;
      settle();
      chk("override high", {4'h0, rr}, 8'h08);
      wr(CRP_A_OVEN, 8'hff);
      wr(CRP_A_CAP0, 8'h3f);
      wr(CRP_A_DIV, 8'h35);
      rc(CRP_A_OVEN, CRP_M_OVEN, "override enables");
      settle();
      chk("enables", {1'b0, cap_ov[3], mux_ov[3], div_ov[3], cap_ov[2:0], mux_ov[0]}, 8'h70);
      chk("cap zero", {3'h0, cap0[19:15]}, CRP_M_CAP);
      chk("cap zero other", {3'h0, cap0[4:0]}, 8'h00);
      chk("divider ratio", {5'h00, div_ratio[11:9]}, 8'h03);
      wr(CRP_A_BOOST, 8'h03);
      wr(CRP_A_LIMIT, 8'h04);
      settle();
      chk("limited boost", {5'h00, boost[11:9]}, 8'h07);
      wr(CRP_A_LIMIT, 8'h00);
      wr(CRP_A_EYE, 8'h00);
      settle();
      chk("boost no limit", {5'h00, boost[11:9]}, 8'h03);
      chk("eye on", {4'h0, eye_pd}, 8'h07);
      wr(CRP_A_SEL, CRP_RV_SEL);
      rc(8'h10, 8'h5a, "shared again");
      rc(CRP_A_DEEMP, 8'ha5 ^ 8'h15, "shared deemph");
      end_sim();
   end
endmodule : test_channel_register_paging
`default_nettype wire
